// ===== include/hdio_pkg.sv
// Constants shared by both ends of the host direct register port
package hdio_pkg;
   // Bus clock is derived from clk; this many clk cycles per half period
   localparam int BCLK_HALF = 32'h2;
   // Bus clock half-edge counts after the sample edge (fall = even, rise = odd)
   localparam logic [3:0] RD_DATA_PH = 4'h6;
   localparam logic [3:0] RD_ACK_PH = 4'h9;
   localparam logic [3:0] WR_BEN_PH = 4'h5;
   localparam logic [3:0] WR_LATCH_PH = 4'h9;
   // Register select codes on the two upper select lines
   localparam logic [1:0] SEL_DATA = 2'h0;
   localparam logic [1:0] SEL_DATA_INC = 2'h1;
   localparam logic [1:0] SEL_POINTER = 2'h2;
   localparam logic [1:0] SEL_IRQ = 2'h3;
   // Reset values and writable field of the interrupt register
   localparam logic [15:0] DATA_RST = 16'h0000;
   localparam logic [15:0] POINTER_RST = 16'h0000;
   localparam logic [15:0] IRQ_RST = 16'h0000;
   localparam logic [15:0] IRQ_WR_MASK = 16'hFF00;
   // Adapter memory model and host pacing
   localparam int MEM_WORDS = 32'h10;
   localparam int MEM_CYCLES = 32'h4;
   localparam int HOST_GAP = 32'h4;
endpackage : hdio_pkg

// ===== include/hdio_if.sv
// Pins between the host and the device, with wire resolution
`timescale 1ns/100ps
interface hdio_if;
   // Host driven control
   logic [2:0] register_select;
   logic read_not_write;
   logic host_chip_select_n;
   logic host_int_ack_n;
   logic upper_byte_strobe_n;
   logic lower_byte_strobe_n;
   logic host_address_strobe_n;
   logic bus_width_select;
   // Host drive of the shared data lanes
   logic [15:0] host_data;
   logic host_data_en;
   logic [1:0] host_par;
   // Device drive of the shared data lanes and the three-state acknowledge
   logic [15:0] dev_data;
   logic dev_hi_en;
   logic dev_lo_en;
   logic [1:0] dev_par;
   logic ack_drive;
   logic ack_en;
   logic buffer_direction;
   logic buffer_enable_n;
   // Resolved wire levels; undriven lanes read zero, acknowledge is pulled up
   logic [15:0] host_addr_data_bus;
   logic high_lane_parity;
   logic low_lane_parity;
   logic transfer_ack_n;

   assign host_addr_data_bus[15:8] = dev_hi_en ? dev_data[15:8] :
                                     host_data_en ? host_data[15:8] : 8'h00;
   assign host_addr_data_bus[7:0] = dev_lo_en ? dev_data[7:0] :
                                    host_data_en ? host_data[7:0] : 8'h00;
   assign high_lane_parity = dev_hi_en ? dev_par[1] : host_data_en & host_par[1];
   assign low_lane_parity = dev_lo_en ? dev_par[0] : host_data_en & host_par[0];
   assign transfer_ack_n = ack_en ? ack_drive : 1'b1;

   modport dev (
      input register_select, read_not_write, host_chip_select_n, host_int_ack_n,
      input upper_byte_strobe_n, lower_byte_strobe_n, host_address_strobe_n,
      input bus_width_select, host_addr_data_bus, transfer_ack_n,
      output dev_data, dev_hi_en, dev_lo_en, dev_par, ack_drive, ack_en,
      output buffer_direction, buffer_enable_n
   );
   modport host (
      output register_select, read_not_write, host_chip_select_n, host_int_ack_n,
      output upper_byte_strobe_n, lower_byte_strobe_n, host_address_strobe_n,
      output bus_width_select, host_data, host_data_en, host_par,
      input host_addr_data_bus, transfer_ack_n, buffer_direction, buffer_enable_n
   );
endinterface : hdio_if

// ===== design/hdio_sync.sv
// Two flip-flop synchroniser for a group of pin levels
`timescale 1ns/100ps
module hdio_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // First stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         meta_reg <= INIT;
         q <= INIT;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule : hdio_sync

// ===== design/hdio_dev.sv
// Device end of the host direct register port with its adapter memory
// Contract
// [RULE_01] Width select low; sixteen bit data path
// [RULE_02] Upper two select lines pick four registers
// [RULE_03] Host asserts one or both byte strobes
// [RULE_04] Idle: bus floated, direction/enable high, ack released
// [RULE_05] Host sets select and direction, then strobes
// [RULE_06] Address strobe accepted but never decoded
// [RULE_07] Read enable low combinationally when not busy
// [RULE_08] Read sampled on falling bus clock edge
// [RULE_09] Read data with odd parity on third fall
// [RULE_10] Byte read floats the unselected lane
// [RULE_11] Read acknowledge on fifth rising edge
// [RULE_12] Host withdraws select, then chip select, strobes; the host drops chip select and both strobes in one cycle and holds select
// [RULE_13] Strobes gone: enable high, ack high, release
// [RULE_14] Host keeps strobes negated between accesses
// [RULE_15] Write direction low once select and strobe
// [RULE_16] Write starts on falling edge sample
// [RULE_17] Write enable low on third rising edge
// [RULE_18] Write waits for pending memory transfer
// [RULE_19] Write data latched on fifth rising edge
// [RULE_20] After latch: enable high, ack, then release
// [RULE_21] Pointer write loads, data write stores memory
// [RULE_22] Busy held until memory transfer finishes
`timescale 1ns/100ps
module hdio_dev #(
   parameter int BCLK_DIV = hdio_pkg::BCLK_HALF,
   parameter int WORDS = hdio_pkg::MEM_WORDS,
   parameter int XFER_CYCLES = hdio_pkg::MEM_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Host pins
   hdio_if.dev bus,
   // User side
   input wire logic [7:0] irq_status,
   output logic [15:0] irq_ctrl,
   output logic mem_busy
);
   import hdio_pkg::*;

   localparam int IDX_W = (WORDS > 1) ? $clog2(WORDS) : 1;

   typedef enum logic [2:0] {
      ST_IDLE, ST_READ, ST_WRITE, ST_WR_ACK, ST_HOLD, ST_ACK_HIGH
   } hdio_dev_state_t;

   hdio_dev_state_t state_reg;
   logic [7:0] div_cnt_reg;
   logic bclk_reg;
   logic [3:0] ph_reg;
   logic [1:0] sel_reg;
   logic [1:0] be_reg;
   logic wr_acc_reg;
   logic wben_reg;
   logic [15:0] data_reg;
   logic [15:0] ptr_reg;
   logic [15:0] irq_reg;
   logic busy_reg;
   logic [7:0] xfer_cnt_reg;
   logic xfer_store_reg;
   logic xfer_inc_reg;
   logic [15:0] mem_reg [WORDS];
   logic [8:0] s_ctl;
   logic [15:0] s_data;
   logic edge_en, fall_en, rise_en;
   logic s_cs_n, s_rnw, s_uds_n, s_lds_n, s_iack_n, s_bws, s_ack;
   logic s_sel, rd_req, wr_req, rd_drive, wr_latch, xfer_done;
   logic raw_strobe, raw_sel;
   logic [15:0] rd_value;
   logic [IDX_W-1:0] load_idx;

   // Host levels cross into clk before any sequencer decision is taken; buffer controls use the raw pins
   // Reset image is the idle pin pattern, so no false select follows reset
   hdio_sync #(.W(9), .INIT(9'h07D)) u_ctl_sync (
      .clk(clk),
      .rst_b(rst_b),
      .d({bus.register_select[2:1], bus.host_chip_select_n, bus.read_not_write,
          bus.upper_byte_strobe_n, bus.lower_byte_strobe_n, bus.host_int_ack_n,
          bus.bus_width_select, bus.transfer_ack_n}),
      .q(s_ctl)
   );
   hdio_sync #(.W(16), .INIT(16'h0000)) u_data_sync (
      .clk(clk),
      .rst_b(rst_b),
      .d(bus.host_addr_data_bus),
      .q(s_data)
   );

   // Address strobe and the lowest select line are deliberately left unused
   assign {s_cs_n, s_rnw, s_uds_n, s_lds_n, s_iack_n, s_bws, s_ack} = s_ctl[6:0]; // [RULE_06]
   assign s_sel = ~s_cs_n & s_iack_n & ~s_bws & (~s_uds_n | ~s_lds_n); // [RULE_01]
   assign rd_req = s_sel & s_rnw & ~busy_reg; // [RULE_08]
   assign wr_req = s_sel & ~s_rnw; // [RULE_16]

   // Bus clock divider; edges become one-cycle enables
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         div_cnt_reg <= 8'h00;
         bclk_reg <= 1'b1;
      end else if (edge_en) begin
         div_cnt_reg <= 8'h00;
         bclk_reg <= ~bclk_reg;
      end else begin
         div_cnt_reg <= div_cnt_reg + 8'h01;
      end
   end
   assign edge_en = (div_cnt_reg == 8'(BCLK_DIV - 1));
   assign fall_en = edge_en & bclk_reg;
   assign rise_en = edge_en & ~bclk_reg;

   // Access pulses seen by the register file
   assign rd_drive = (state_reg == ST_READ) & edge_en & (ph_reg + 4'h1 == RD_DATA_PH);
   assign wr_latch = (state_reg == ST_WRITE) & rise_en & (ph_reg >= WR_LATCH_PH - 4'h1)
                     & ~busy_reg; // [RULE_18]
   assign xfer_done = busy_reg & (xfer_cnt_reg == 8'(XFER_CYCLES - 1));

   // Access sequencer; read and write phases step on bus clock edges, the ack states on clk
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_reg <= ST_IDLE;
         ph_reg <= 4'h0;
         sel_reg <= SEL_DATA;
         be_reg <= 2'h0;
         wr_acc_reg <= 1'b0;
         wben_reg <= 1'b0;
         bus.ack_drive <= 1'b1;
         bus.ack_en <= 1'b0; // [RULE_04]
      end else begin
         case (state_reg)
            ST_IDLE: begin
               ph_reg <= 4'h0;
               if (fall_en && (rd_req || wr_req)) begin
                  sel_reg <= s_ctl[8:7]; // [RULE_02]
                  be_reg <= {~s_uds_n, ~s_lds_n};
                  wr_acc_reg <= wr_req;
                  state_reg <= wr_req ? ST_WRITE : ST_READ;
               end
            end
            ST_READ: begin
               if (edge_en) begin
                  ph_reg <= ph_reg + 4'h1;
               end
               if (edge_en && ph_reg + 4'h1 == RD_ACK_PH) begin
                  bus.ack_drive <= 1'b0; // [RULE_11]
                  bus.ack_en <= 1'b1;
                  state_reg <= ST_HOLD;
               end
            end
            ST_WRITE: begin
               // Phase count parks before the latch edge while memory is busy
               if (edge_en && ph_reg < WR_LATCH_PH - 4'h1) begin
                  ph_reg <= ph_reg + 4'h1;
               end
               if (edge_en && ph_reg + 4'h1 == WR_BEN_PH) begin
                  wben_reg <= 1'b1; // [RULE_17]
               end
               if (wr_latch) begin
                  wben_reg <= 1'b0; // [RULE_20]
                  state_reg <= ST_WR_ACK;
               end
            end
            ST_WR_ACK: begin
               // Enable is our own flop, so it is high at the pin by now
               bus.ack_drive <= 1'b0; // [RULE_20]
               bus.ack_en <= 1'b1;
               state_reg <= ST_HOLD;
            end
            ST_HOLD: begin
               if (s_cs_n && s_uds_n && s_lds_n) begin
                  bus.ack_drive <= 1'b1; // [RULE_13]
                  state_reg <= ST_ACK_HIGH;
               end
            end
            ST_ACK_HIGH: begin
               if (s_ack) begin
                  bus.ack_en <= 1'b0; // [RULE_13]
                  wr_acc_reg <= 1'b0;
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Read lanes follow the strobes; lanes float again once strobes are gone
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         bus.dev_data <= 16'h0000;
         bus.dev_par <= 2'h0;
         bus.dev_hi_en <= 1'b0;
         bus.dev_lo_en <= 1'b0;
      end else if (rd_drive) begin
         bus.dev_data <= rd_value; // [RULE_09]
         bus.dev_par <= {~^rd_value[15:8], ~^rd_value[7:0]};
         bus.dev_hi_en <= be_reg[1]; // [RULE_10]
         bus.dev_lo_en <= be_reg[0];
      end else if (state_reg == ST_HOLD && s_cs_n && s_uds_n && s_lds_n) begin
         bus.dev_hi_en <= 1'b0;
         bus.dev_lo_en <= 1'b0;
      end
   end

   // Direction and read enable straight from the pins; they must not wait for clk
   assign raw_strobe = ~bus.upper_byte_strobe_n | ~bus.lower_byte_strobe_n;
   assign raw_sel = ~bus.host_chip_select_n & raw_strobe;
   always_comb begin
      bus.buffer_enable_n = ~wben_reg;
      if (raw_sel && bus.host_int_ack_n && !wr_acc_reg && (bus.read_not_write ||
          state_reg != ST_IDLE) && (state_reg != ST_IDLE || !busy_reg)) begin
         bus.buffer_enable_n = 1'b0; // [RULE_07]
      end
      bus.buffer_direction = ~(raw_sel && (!bus.read_not_write || wr_acc_reg)); // [RULE_15]
   end

   // Register read mux
   always_comb begin
      if (sel_reg == SEL_POINTER) begin
         rd_value = ptr_reg;
      end else if (sel_reg == SEL_IRQ) begin
         rd_value = {irq_reg[15:8], irq_status};
      end else begin
         rd_value = data_reg;
      end
   end

   // Register file and memory transfers; unselected write lanes are ignored
   assign load_idx = xfer_inc_reg ? IDX_W'(ptr_reg + 16'h0001) : ptr_reg[IDX_W-1:0];
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         data_reg <= DATA_RST;
         ptr_reg <= POINTER_RST;
         irq_reg <= IRQ_RST;
         busy_reg <= 1'b0;
         xfer_cnt_reg <= 8'h00;
         xfer_store_reg <= 1'b0;
         xfer_inc_reg <= 1'b0;
      end else begin
         xfer_cnt_reg <= busy_reg ? xfer_cnt_reg + 8'h01 : 8'h00;
         if (xfer_done) begin
            busy_reg <= 1'b0; // [RULE_22]
            if (xfer_inc_reg) begin
               ptr_reg <= ptr_reg + 16'h0001;
            end
            if (!xfer_store_reg) begin
               data_reg <= mem_reg[load_idx]; // [RULE_21]
            end
         end
         if (wr_latch) begin
            if (sel_reg == SEL_IRQ) begin
               if (be_reg[1]) irq_reg[15:8] <= s_data[15:8] & IRQ_WR_MASK[15:8];
            end else begin
               if (be_reg[1]) begin
                  if (sel_reg == SEL_POINTER) ptr_reg[15:8] <= s_data[15:8];
                  else data_reg[15:8] <= s_data[15:8]; // [RULE_19]
               end
               if (be_reg[0]) begin
                  if (sel_reg == SEL_POINTER) ptr_reg[7:0] <= s_data[7:0];
                  else data_reg[7:0] <= s_data[7:0];
               end
               busy_reg <= 1'b1; // [RULE_22]
               xfer_cnt_reg <= 8'h00;
               xfer_store_reg <= (sel_reg != SEL_POINTER); // [RULE_21]
               xfer_inc_reg <= (sel_reg == SEL_DATA_INC);
            end
         end else if (rd_drive && sel_reg == SEL_DATA_INC) begin
            // Auto-increment read fetches the next word behind the host
            busy_reg <= 1'b1;
            xfer_cnt_reg <= 8'h00;
            xfer_store_reg <= 1'b0;
            xfer_inc_reg <= 1'b1;
         end
      end
   end

   // Adapter memory words, written when a store completes
   always_ff @(posedge clk) begin
      if (xfer_done && xfer_store_reg) begin
         mem_reg[ptr_reg[IDX_W-1:0]] <= data_reg;
      end
   end

   assign irq_ctrl = irq_reg;
   assign mem_busy = busy_reg;
endmodule : hdio_dev

// ===== design/hdio_host.sv
// Host end: runs one register access on the device pins per request
`timescale 1ns/100ps
module hdio_host #(
   parameter int GAP_CYCLES = hdio_pkg::HOST_GAP
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Device pins
   hdio_if.host bus,
   // Request
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_read,
   input wire logic [1:0] req_sel,
   input wire logic [1:0] req_be,
   input wire logic [15:0] req_wdata,
   // Answer
   output logic rsp_valid,
   output logic [15:0] rsp_rdata
);
   import hdio_pkg::*;

   typedef enum logic [2:0] {
      HS_IDLE, HS_SETUP, HS_CS, HS_STROBE, HS_RELEASE, HS_GAP
   } hdio_host_state_t;

   hdio_host_state_t state_reg;
   logic [1:0] be_reg;
   logic [7:0] gap_reg;
   logic s_ack;
   logic [15:0] s_data;

   // Acknowledge and read data are pins from the other end
   hdio_sync #(.W(17), .INIT(17'h10000)) u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .d({bus.transfer_ack_n, bus.host_addr_data_bus}),
      .q({s_ack, s_data})
   );

   // Fixed levels: sixteen bit mode, no interrupt acknowledge cycles
   assign bus.bus_width_select = 1'b0; // [RULE_01]
   assign bus.host_int_ack_n = 1'b1; // [RULE_04]
   assign bus.host_address_strobe_n = bus.host_chip_select_n;
   assign bus.host_par = {~^bus.host_data[15:8], ~^bus.host_data[7:0]};
   assign req_ready = (state_reg == HS_IDLE);

   // Access sequence; no-strobe requests are never started
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_reg <= HS_IDLE;
         be_reg <= 2'h0;
         gap_reg <= 8'h00;
         bus.register_select <= 3'h0;
         bus.read_not_write <= 1'b1;
         bus.host_chip_select_n <= 1'b1;
         bus.upper_byte_strobe_n <= 1'b1;
         bus.lower_byte_strobe_n <= 1'b1;
         bus.host_data <= 16'h0000;
         bus.host_data_en <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= 16'h0000;
      end else begin
         rsp_valid <= 1'b0;
         case (state_reg)
            HS_IDLE: begin
               if (req_valid && req_be != 2'h0) begin // [RULE_03]
                  bus.register_select <= {req_sel, 1'b0}; // [RULE_05]
                  bus.read_not_write <= req_read;
                  bus.host_data <= req_wdata;
                  be_reg <= req_be;
                  state_reg <= HS_SETUP;
               end
            end
            HS_SETUP: begin
               bus.host_chip_select_n <= 1'b0; // [RULE_05]
               state_reg <= HS_CS;
            end
            HS_CS: begin
               bus.upper_byte_strobe_n <= ~be_reg[1]; // [RULE_03]
               bus.lower_byte_strobe_n <= ~be_reg[0];
               bus.host_data_en <= ~bus.read_not_write;
               state_reg <= HS_STROBE;
            end
            HS_STROBE: begin
               if (!s_ack) begin
                  // Read data was valid before the acknowledge fell
                  rsp_rdata <= bus.read_not_write ? s_data : 16'h0000;
                  rsp_valid <= 1'b1;
                  bus.host_chip_select_n <= 1'b1; // [RULE_12]
                  bus.upper_byte_strobe_n <= 1'b1;
                  bus.lower_byte_strobe_n <= 1'b1;
                  bus.host_data_en <= 1'b0;
                  state_reg <= HS_RELEASE;
               end
            end
            HS_RELEASE: begin
               gap_reg <= 8'h00;
               if (s_ack) begin
                  state_reg <= HS_GAP;
               end
            end
            HS_GAP: begin
               gap_reg <= gap_reg + 8'h01;
               if (gap_reg == 8'(GAP_CYCLES - 1)) begin
                  state_reg <= HS_IDLE; // [RULE_14]
               end
            end
            default: begin
               state_reg <= HS_IDLE;
            end
         endcase
      end
   end
endmodule : hdio_host

// ===== tb/hdio_props.sv
// Concurrent checks on the pins between the host and device ends
`timescale 1ns/100ps
module hdio_props (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Host driven pins
   input wire logic read_not_write,
   input wire logic host_chip_select_n,
   input wire logic upper_byte_strobe_n,
   input wire logic lower_byte_strobe_n,
   // Device drive and resolved pins
   input wire logic [15:0] dev_data,
   input wire logic dev_hi_en,
   input wire logic dev_lo_en,
   input wire logic [1:0] dev_par,
   input wire logic ack_en,
   input wire logic transfer_ack_n,
   input wire logic buffer_direction,
   input wire logic buffer_enable_n
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   // Read data lanes switch on
   sequence s_rd_lanes;
      $rose(dev_hi_en || dev_lo_en) && read_not_write;
   endsequence
   // Write buffers opened toward the device
   sequence s_wr_open;
      $fell(buffer_enable_n) && !buffer_direction;
   endsequence

   a_idle_pins_high: assert property (host_chip_select_n && upper_byte_strobe_n &&
      lower_byte_strobe_n |-> buffer_direction && buffer_enable_n)
      else $error("idle buffer controls not high");
   a_write_dir_low: assert property (!host_chip_select_n && !read_not_write &&
      !(upper_byte_strobe_n && lower_byte_strobe_n) |-> !buffer_direction)
      else $error("write direction not low");
   a_lane_upper_only: assert property ($rose(dev_hi_en) |-> !upper_byte_strobe_n)
      else $error("upper lane driven without its strobe");
   a_lane_lower_only: assert property ($rose(dev_lo_en) |-> !lower_byte_strobe_n)
      else $error("lower lane driven without its strobe");
   a_parity_odd: assert property ((dev_hi_en || dev_lo_en) |->
      (!dev_hi_en || ^{dev_data[15:8], dev_par[1]}) && (!dev_lo_en || ^{dev_data[7:0], dev_par[0]}))
      else $error("lane parity not odd");
   a_read_ack_time: assert property (s_rd_lanes |-> transfer_ack_n[*6] ##1 !transfer_ack_n)
      else $error("read acknowledge not six cycles after data");
   a_ack_in_access: assert property ($fell(transfer_ack_n) |-> !host_chip_select_n)
      else $error("acknowledge outside an access");
   a_ack_release: assert property ($rose(transfer_ack_n) |-> ##[1:8] !ack_en)
      else $error("acknowledge not released");
   a_wr_enable_span: assert property (s_wr_open |-> !buffer_enable_n[*8] ##[1:32] buffer_enable_n)
      else $error("write enable span wrong");
   a_wr_ack_after: assert property ($rose(buffer_enable_n) && !buffer_direction
      |-> ##[1:2] !transfer_ack_n)
      else $error("write acknowledge late");
endmodule : hdio_props

// ===== tb/tb_top.sv
// Testbench joining the host and device ends through the shared pins
`timescale 1ns/100ps
module tb_top;
   import hdio_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic req_valid = 1'b0;
   logic req_ready;
   logic req_read = 1'b0;
   logic [1:0] req_sel = 2'h0;
   logic [1:0] req_be = 2'h0;
   logic [15:0] req_wdata = 16'h0000;
   logic rsp_valid;
   logic [15:0] rsp_rdata;
   logic [7:0] irq_status = 8'h00;
   logic [15:0] irq_ctrl;
   logic mem_busy;
   logic [15:0] exp_q[$];
   logic [15:0] d0;
   logic [15:0] d1;
   int n_mismatch = 0;
   int comparisons = 0;
   int cycles = 0;

   hdio_if bus_if ();
   hdio_dev u_hdio_dev (.clk(clk), .rst_b(rst_b), .bus(bus_if.dev), .irq_status(irq_status),
      .irq_ctrl(irq_ctrl), .mem_busy(mem_busy));
   hdio_host u_hdio_host (.clk(clk), .rst_b(rst_b), .bus(bus_if.host), .req_valid(req_valid),
      .req_ready(req_ready), .req_read(req_read), .req_sel(req_sel), .req_be(req_be),
      .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
   hdio_props u_hdio_props (.clk(clk), .rst_b(rst_b), .read_not_write(bus_if.read_not_write),
      .host_chip_select_n(bus_if.host_chip_select_n),
      .upper_byte_strobe_n(bus_if.upper_byte_strobe_n),
      .lower_byte_strobe_n(bus_if.lower_byte_strobe_n), .dev_data(bus_if.dev_data),
      .dev_hi_en(bus_if.dev_hi_en), .dev_lo_en(bus_if.dev_lo_en), .dev_par(bus_if.dev_par),
      .ack_en(bus_if.ack_en), .transfer_ack_n(bus_if.transfer_ack_n),
      .buffer_direction(bus_if.buffer_direction), .buffer_enable_n(bus_if.buffer_enable_n));

   // 40 MHz clock
   always #12.5 clk = ~clk;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wrap_up();
      $display("Mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : wrap_up

   // One host request; ready is stable at the falling edge since it only moves on rising ones
   task automatic access(input logic rd, input logic [1:0] sel, input logic [1:0] be,
                         input logic [15:0] wd, input logic [15:0] exp);
      int i;
      i = 0;
      while (req_ready !== 1'b1 && i < 400) begin
         @(negedge clk);
         i++;
      end
      if (i >= 400) n_mismatch++;
      exp_q.push_back(rd ? exp : 16'h0000);
      req_valid = 1'b1;
      req_read = rd;
      req_sel = sel;
      req_be = be;
      req_wdata = wd;
      @(negedge clk);
      req_valid = 1'b0;
      @(negedge clk);
   endtask : access

   // Answers are paired with the oldest note in arrival order
   always @(negedge clk) begin
      if (rsp_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            check(rsp_rdata, ~rsp_rdata);
         end else begin
            check(rsp_rdata, exp_q.pop_front());
         end
      end
   end

   // Hang guard, well above the thousand or so cycles the sequence needs
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         wrap_up();
      end
   end

   initial begin
      void'($urandom(32'h5810));
      d0 = 16'($urandom);
      d1 = 16'($urandom);
      irq_status = 8'($urandom);
      repeat (6) @(negedge clk);
      rst_b = 1'b1;
      @(negedge clk);
      check({11'h000, bus_if.transfer_ack_n, bus_if.buffer_direction, bus_if.buffer_enable_n,
             bus_if.dev_hi_en, bus_if.dev_lo_en}, 16'h001C);
      // Pointer word write, then an upper byte write leaves the low byte alone
      access(1'b0, SEL_POINTER, 2'h3, 16'h1205, 16'h0000);
      access(1'b0, SEL_POINTER, 2'h2, 16'h34FF, 16'h0000);
      access(1'b1, SEL_POINTER, 2'h3, 16'h0000, 16'h3405);
      // Auto-increment writes store and advance the pointer
      access(1'b0, SEL_DATA_INC, 2'h3, d0, 16'h0000);
      access(1'b0, SEL_DATA_INC, 2'h3, d1, 16'h0000);
      access(1'b1, SEL_POINTER, 2'h3, 16'h0000, 16'h3407);
      // Pointer write reloads the data register from memory
      access(1'b0, SEL_POINTER, 2'h3, 16'h3405, 16'h0000);
      access(1'b1, SEL_DATA_INC, 2'h3, 16'h0000, d0);
      // Byte reads float the other lane, which reads back as zero here
      access(1'b1, SEL_DATA, 2'h2, 16'h0000, {d1[15:8], 8'h00});
      access(1'b1, SEL_DATA, 2'h1, 16'h0000, {8'h00, d1[7:0]});
      // Low byte write into data, then read back after a reload from memory
      access(1'b0, SEL_DATA, 2'h1, 16'h55AA, 16'h0000);
      access(1'b0, SEL_POINTER, 2'h3, 16'h3406, 16'h0000);
      access(1'b1, SEL_DATA, 2'h3, 16'h0000, {d1[15:8], 8'hAA});
      // Interrupt register keeps only its upper byte, low byte reports status
      access(1'b0, SEL_IRQ, 2'h3, 16'hFFFF, 16'h0000);
      access(1'b1, SEL_IRQ, 2'h3, 16'h0000, {8'hFF, irq_status});
      repeat (200) @(negedge clk);
      check(16'(exp_q.size()), 16'h0000);
      check(irq_ctrl, 16'hFF00);
      check({15'h0000, mem_busy}, 16'h0000);
      check({11'h000, bus_if.transfer_ack_n, bus_if.buffer_direction, bus_if.buffer_enable_n,
             bus_if.dev_hi_en, bus_if.dev_lo_en}, 16'h001C);
      wrap_up();
   end
endmodule : tb_top
